/* File: rtl/general_timer_module.sv */
`timescale 1ns/10ps
module general_timer_module
  import gen_timer_pkg::*;
(
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // Configuration and control
  input  wire logic [2:0]               timer_configuration_reg,
  input  wire gen_timer_pkg::timer_mode_s timer_a_mode_reg,
  input  wire gen_timer_pkg::timer_mode_s timer_b_mode_reg,
  input  wire gen_timer_pkg::timer_ctl_s  timer_a_ctl,
  input  wire gen_timer_pkg::timer_ctl_s  timer_b_ctl,
  input  wire logic                     rtc_enable_bit,
  input  wire logic                     set_enable_a,
  input  wire logic                     set_enable_b,
  input  wire logic                     clear_enable_a,
  input  wire logic                     clear_enable_b,
  // Load values, one-cycle write strobes
  input  wire logic [15:0]              load_a_data,
  input  wire logic [15:0]              load_b_data,
  input  wire logic                     load_a_wr,
  input  wire logic                     load_b_wr,
  input  wire logic [7:0]               prescale_a_data,
  input  wire logic [7:0]               prescale_b_data,
  input  wire logic                     prescale_a_wr,
  input  wire logic                     prescale_b_wr,
  input  wire logic [15:0]              timer_a_match_value,
  input  wire logic [15:0]              timer_b_match_value,
  // Interrupt mask and clear
  input  wire gen_timer_pkg::timer_irq_s  interrupt_mask_a,
  input  wire gen_timer_pkg::timer_irq_s  interrupt_mask_b,
  input  wire logic                     rtc_interrupt_mask,
  input  wire gen_timer_pkg::timer_irq_s  interrupt_clear_a,
  input  wire gen_timer_pkg::timer_irq_s  interrupt_clear_b,
  input  wire logic                     rtc_flag_clear,
  // Debug halt and pins
  input  wire logic                     debug_halt,
  input  wire logic                     capture_compare_pin_a,
  input  wire logic                     capture_compare_pin_b,
  // Status and outputs
  output logic                          timer_a_enable,
  output logic                          timer_b_enable,
  output logic [15:0]                   timer_a_count_capture,
  output logic [15:0]                   timer_b_count_capture,
  output logic [31:0]                   rtc_count,
  output gen_timer_pkg::timer_irq_s     raw_interrupt_flags_a,
  output gen_timer_pkg::timer_irq_s     raw_interrupt_flags_b,
  output gen_timer_pkg::timer_irq_s     masked_interrupt_flags_a,
  output gen_timer_pkg::timer_irq_s     masked_interrupt_flags_b,
  output logic                          rtc_raw_flag,
  output logic                          rtc_masked_flag,
  output logic                          controller_interrupt,
  output logic                          adc_trigger,
  output logic                          pwm_out_a,
  output logic                          pwm_out_b
);
  import gen_timer_pkg::*;

  function automatic logic is_pwm(input timer_mode_s m);
    is_pwm = m.alternate_mode_select && !m.capture_mode_bit
             && (m.mode_field == MODE_PERIODIC);
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                    input logic fall, input logic both_ok);
    unique case (sel)
      EVT_RISING:  edge_hit = rise;
      EVT_FALLING: edge_hit = fall;
      EVT_BOTH:    edge_hit = both_ok && (rise || fall);
      default:     edge_hit = 1'b0;
    endcase
  endfunction

  // Pin synchronisers: stage one is read only by stage two
  logic [1:0] pin_s1_r, pin_s2_r, pin_s3_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      pin_s3_r <= 2'h0;
    end else begin
      pin_s1_r <= {capture_compare_pin_b, capture_compare_pin_a};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end
  wire logic [1:0] rise = pin_s2_r & ~pin_s3_r;
  wire logic [1:0] fall = ~pin_s2_r & pin_s3_r;

  wire logic split = (timer_configuration_reg == CFG_16_SPLIT);
  wire logic rtc_mode = (timer_configuration_reg == CFG_32_RTC);
  wire logic t32_mode = (timer_configuration_reg == CFG_32_TIMER);

  // Per-timer state, index 0 is timer A, 1 is timer B
  logic [15:0] cnt_r [2], cnt_nxt [2];
  logic [15:0] load_r [2], load_nxt [2];
  logic [7:0]  pre_r [2], pre_nxt [2];
  logic [7:0]  pcnt_r [2], pcnt_nxt [2];
  logic [15:0] cap_r [2], cap_nxt [2];
  logic [1:0]  en_r, en_nxt;
  timer_irq_s  raw_r [2], raw_nxt [2];
  logic [1:0]  pwm_r, pwm_nxt, trig_r, trig_nxt;
  logic [1:0]  zero_hit;

  // 32-bit joined view and RTC state
  logic [31:0] rtc_cnt_r, rtc_cnt_nxt;
  logic [14:0] rtc_div_r, rtc_div_nxt;
  logic        rtc_seen_r, rtc_seen_nxt, rtc_raw_r, rtc_raw_nxt;

  timer_mode_s mode_v [2];
  timer_ctl_s  ctl_v [2];
  timer_irq_s  mask_v [2], clr_v [2];
  logic [1:0]  set_en, clr_en, load_wr, pre_wr, pin_rise, pin_fall;
  logic [15:0] load_d [2], match_v [2];
  logic [7:0]  pre_d [2];
  assign mode_v  = '{timer_a_mode_reg, timer_b_mode_reg};
  assign ctl_v   = '{timer_a_ctl, timer_b_ctl};
  assign mask_v  = '{interrupt_mask_a, interrupt_mask_b};
  assign clr_v   = '{interrupt_clear_a, interrupt_clear_b};
  assign load_d  = '{load_a_data, load_b_data};
  assign match_v = '{timer_a_match_value, timer_b_match_value};
  assign pre_d   = '{prescale_a_data, prescale_b_data};
  assign set_en  = {set_enable_b, set_enable_a};
  assign clr_en  = {clear_enable_b, clear_enable_a};
  assign load_wr = {load_b_wr, load_a_wr};
  assign pre_wr  = {prescale_b_wr, prescale_a_wr};

  // Halt freezes the RTC only when either timer's stall is enabled and rtc_enable_bit is off
  wire logic any_stall = timer_a_ctl.stall_enable || timer_b_ctl.stall_enable;
  wire logic rtc_halted = debug_halt && any_stall && !rtc_enable_bit;

  // 32-bit joined down counter, used only in configuration 0
  wire logic [31:0] c32 = {cnt_r[1], cnt_r[0]};
  wire logic [31:0] l32 = {load_r[1], load_r[0]};
  wire logic        run32 = t32_mode && en_r[0] && !(debug_halt && timer_a_ctl.stall_enable);
  wire logic [31:0] c32_nxt = (c32 == 32'h0) ? l32 : c32 - 32'h1;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      logic run, is_cap, is_cnt_edge, ev, presc_ok;
      run = 1'b0;
      is_cap = 1'b0;
      is_cnt_edge = 1'b0;
      ev = 1'b0;
      presc_ok = 1'b0;
      cnt_nxt[i]  = cnt_r[i];
      load_nxt[i] = load_wr[i] ? load_d[i] : load_r[i];
      pre_nxt[i]  = pre_wr[i] ? pre_d[i] : pre_r[i];
      pcnt_nxt[i] = pcnt_r[i];
      cap_nxt[i]  = cap_r[i];
      en_nxt[i]   = (en_r[i] || set_en[i]) && !clr_en[i];
      raw_nxt[i]  = raw_r[i] & ~clr_v[i];
      pwm_nxt[i]  = pwm_r[i];
      trig_nxt[i] = 1'b0;
      zero_hit[i] = 1'b0;
      run = split && en_r[i] && !(debug_halt && ctl_v[i].stall_enable);
      is_cap = (mode_v[i].mode_field == MODE_CAPTURE) && !mode_v[i].alternate_mode_select;
      // Stopped timers take the load too, so enable starts from it
      if (load_wr[i] && split && (run || !en_r[i])) begin
        cnt_nxt[i] = load_d[i];
        pcnt_nxt[i] = pre_r[i];
      end else if (run && is_pwm(mode_v[i])) begin
        cnt_nxt[i] = (cnt_r[i] == 16'h0) ? load_r[i] : cnt_r[i] - 16'h1;
        if (cnt_r[i] == load_r[i]) pwm_nxt[i] = 1'b1;
        else if (cnt_r[i] == match_v[i]) pwm_nxt[i] = 1'b0;
      end else if (run && is_cap && !mode_v[i].capture_mode_bit) begin
        is_cnt_edge = edge_hit(ctl_v[i].edge_event_select, rise[i], fall[i], 1'b1);
        if (is_cnt_edge) begin
          if (cnt_r[i] - 16'h1 == match_v[i]) begin
            cnt_nxt[i] = load_r[i];
            en_nxt[i] = 1'b0;
            raw_nxt[i].cap_match = 1'b1;
          end else begin
            cnt_nxt[i] = cnt_r[i] - 16'h1;
          end
        end
      end else if (run && is_cap) begin
        cnt_nxt[i] = (cnt_r[i] == 16'h0) ? load_r[i] : cnt_r[i] - 16'h1;
        ev = edge_hit(ctl_v[i].edge_event_select, rise[i], fall[i], 1'b0);
        if (ev) begin
          cap_nxt[i] = cnt_r[i];
          raw_nxt[i].cap_event = 1'b1;
        end
      end else if (run) begin
        presc_ok = (pcnt_r[i] == 8'h0);
        pcnt_nxt[i] = presc_ok ? pre_r[i] : pcnt_r[i] - 8'h1;
        if (presc_ok) begin
          if (cnt_r[i] == 16'h0) begin
            zero_hit[i] = 1'b1;
            cnt_nxt[i] = load_r[i];
            pcnt_nxt[i] = pre_r[i];
            if (mode_v[i].mode_field == MODE_ONE_SHOT) en_nxt[i] = 1'b0;
          end else begin
            cnt_nxt[i] = cnt_r[i] - 16'h1;
          end
        end
      end
      if (zero_hit[i]) begin
        raw_nxt[i].timeout = 1'b1;
        trig_nxt[i] = mask_v[i].timeout && ctl_v[i].adc_trigger_enable;
      end
      // Only edge time holds a captured value; edge count shows its count
      if (!(is_cap && mode_v[i].capture_mode_bit)) cap_nxt[i] = cnt_nxt[i];
    end
    // Joined 32-bit mode overrides the halves; load strobe a writes both
    if (t32_mode && load_wr[0]) load_nxt[1] = load_d[1];
    if (t32_mode && load_wr[0] && (run32 || !en_r[0])) begin
      {cnt_nxt[1], cnt_nxt[0]} = {load_d[1], load_d[0]};
    end else if (run32) begin
      {cnt_nxt[1], cnt_nxt[0]} = c32_nxt;
      if (c32 == 32'h0) begin
        raw_nxt[0].timeout = 1'b1;
        trig_nxt[0] = mask_v[0].timeout && timer_a_ctl.adc_trigger_enable;
        if (mode_v[0].mode_field == MODE_ONE_SHOT) en_nxt[0] = 1'b0;
      end
    end
    if (t32_mode) begin
      cap_nxt[0] = cnt_nxt[0];
      cap_nxt[1] = cnt_nxt[1];
    end
  end

  // RTC: 1 Hz tick from 32.768 kHz pin, counter counts up, rolls on match
  always_comb begin
    rtc_cnt_nxt  = rtc_cnt_r;
    rtc_div_nxt  = rtc_div_r;
    rtc_seen_nxt = rtc_seen_r;
    rtc_raw_nxt  = rtc_raw_r && !rtc_flag_clear;
    if (rtc_mode && !rtc_seen_r) begin
      rtc_cnt_nxt  = RTC_FIRST_LOAD;
      rtc_seen_nxt = 1'b1;
      rtc_div_nxt  = 15'h0;
    end else if (rtc_mode && en_r[0] && !rtc_halted && rise[0]) begin
      rtc_div_nxt = (rtc_div_r == RTC_DIV_LAST) ? 15'h0 : rtc_div_r + 15'h1;
      if (rtc_div_r == RTC_DIV_LAST) begin
        if (rtc_cnt_r == {timer_b_match_value, timer_a_match_value}) begin
          rtc_cnt_nxt = RTC_ROLL_VALUE;
          rtc_raw_nxt = 1'b1;
        end else begin
          rtc_cnt_nxt = rtc_cnt_r + 32'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        cnt_r[i]  <= LOAD_RESET;
        load_r[i] <= LOAD_RESET;
        pre_r[i]  <= PRESCALE_RESET;
        pcnt_r[i] <= PRESCALE_RESET;
        cap_r[i]  <= LOAD_RESET;
        raw_r[i]  <= '0;
      end
      en_r       <= 2'h0;
      pwm_r      <= 2'h0;
      trig_r     <= 2'h0;
      rtc_cnt_r  <= 32'h0;
      rtc_div_r  <= 15'h0;
      rtc_seen_r <= 1'b0;
      rtc_raw_r  <= 1'b0;
    end else begin
      cnt_r      <= cnt_nxt;
      load_r     <= load_nxt;
      pre_r      <= pre_nxt;
      pcnt_r     <= pcnt_nxt;
      cap_r      <= cap_nxt;
      raw_r      <= raw_nxt;
      en_r       <= en_nxt;
      pwm_r      <= pwm_nxt;
      trig_r     <= trig_nxt;
      rtc_cnt_r  <= rtc_cnt_nxt;
      rtc_div_r  <= rtc_div_nxt;
      rtc_seen_r <= rtc_seen_nxt;
      rtc_raw_r  <= rtc_raw_nxt;
    end
  end

  // Outputs; masked flags are combinational views of raw and mask
  assign timer_a_enable           = en_r[0];
  assign timer_b_enable           = en_r[1];
  assign timer_a_count_capture    = cap_r[0];
  assign timer_b_count_capture    = cap_r[1];
  assign rtc_count                = rtc_cnt_r;
  assign raw_interrupt_flags_a    = raw_r[0];
  assign raw_interrupt_flags_b    = raw_r[1];
  assign masked_interrupt_flags_a = raw_r[0] & mask_v[0];
  assign masked_interrupt_flags_b = raw_r[1] & mask_v[1];
  assign rtc_raw_flag             = rtc_raw_r;
  assign rtc_masked_flag          = rtc_raw_r && rtc_interrupt_mask;
  assign controller_interrupt     = rtc_masked_flag || (|masked_interrupt_flags_a)
                                    || (|masked_interrupt_flags_b);
  assign adc_trigger              = |trig_r;
  // PWM level invert applied at the pin, register holds true level
  assign pwm_out_a = split && is_pwm(mode_v[0]) && (pwm_r[0] ^ timer_a_ctl.pwm_output_invert);
  assign pwm_out_b = split && is_pwm(mode_v[1]) && (pwm_r[1] ^ timer_b_ctl.pwm_output_invert);
endmodule

/* File: rtl/gen_timer_pkg.sv */
package gen_timer_pkg;
  localparam logic [2:0]  CFG_32_TIMER   = 3'h0;
  localparam logic [2:0]  CFG_32_RTC     = 3'h1;
  localparam logic [2:0]  CFG_16_SPLIT   = 3'h4;
  localparam logic [1:0]  MODE_ONE_SHOT  = 2'h1;
  localparam logic [1:0]  MODE_PERIODIC  = 2'h2;
  localparam logic [1:0]  MODE_CAPTURE   = 2'h3;
  localparam logic [1:0]  EVT_RISING     = 2'h0;
  localparam logic [1:0]  EVT_FALLING    = 2'h1;
  localparam logic [1:0]  EVT_BOTH       = 2'h3;
  localparam logic [15:0] LOAD_RESET     = 16'hffff;
  localparam logic [7:0]  PRESCALE_RESET = 8'h00;
  localparam logic [31:0] RTC_FIRST_LOAD = 32'h0000_0001;
  localparam logic [31:0] RTC_ROLL_VALUE = 32'h0000_0000;
  localparam int          RTC_CLK_HZ     = 32768;
  localparam int          RTC_TICK_HZ    = 1;
  localparam logic [14:0] RTC_DIV_LAST   = 15'(RTC_CLK_HZ / RTC_TICK_HZ - 1);

  typedef struct packed {
    logic [1:0] mode_field;
    logic       capture_mode_bit;
    logic       alternate_mode_select;
  } timer_mode_s;

  typedef struct packed {
    logic       enable;
    logic       stall_enable;
    logic [1:0] edge_event_select;
    logic       adc_trigger_enable;
    logic       pwm_output_invert;
  } timer_ctl_s;

  // Per-timer interrupt bits: time-out, capture match, capture event
  typedef struct packed {
    logic timeout;
    logic cap_match;
    logic cap_event;
  } timer_irq_s;
endpackage

/* File: testbench/timer_props_properties.sv */
`timescale 1ns/10ps
module timer_props
  import gen_timer_pkg::*;
(
  // Clock and reset
  input wire logic                       ref_clk,
  input wire logic                       rst,
  // Configuration and strobes
  input wire logic [2:0]                 timer_configuration_reg,
  input wire gen_timer_pkg::timer_mode_s timer_a_mode_reg,
  input wire gen_timer_pkg::timer_mode_s timer_b_mode_reg,
  input wire gen_timer_pkg::timer_ctl_s  timer_a_ctl,
  input wire logic                       debug_halt,
  input wire logic                       load_a_wr,
  input wire logic [15:0]                load_a_data,
  input wire logic                       set_enable_a,
  input wire logic                       clear_enable_a,
  input wire gen_timer_pkg::timer_irq_s  interrupt_mask_a,
  input wire gen_timer_pkg::timer_irq_s  interrupt_clear_a,
  // Observed outputs
  input wire logic                       timer_a_enable,
  input wire logic [15:0]                timer_a_count_capture,
  input wire logic [31:0]                rtc_count,
  input wire gen_timer_pkg::timer_irq_s  raw_interrupt_flags_a,
  input wire gen_timer_pkg::timer_irq_s  raw_interrupt_flags_b,
  input wire gen_timer_pkg::timer_irq_s  masked_interrupt_flags_a,
  input wire gen_timer_pkg::timer_irq_s  masked_interrupt_flags_b,
  input wire logic                       rtc_masked_flag,
  input wire logic                       controller_interrupt,
  input wire logic                       adc_trigger
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire split_w = timer_configuration_reg == CFG_16_SPLIT;
  wire tmr_a_w = split_w && timer_a_mode_reg.mode_field != MODE_CAPTURE;

  adc_with_timeout_a: assert property (adc_trigger |-> raw_interrupt_flags_a.timeout || raw_interrupt_flags_b.timeout)
    else $error("adc trigger without time-out flag");
  timeout_sticky_a: assert property (raw_interrupt_flags_a.timeout && !interrupt_clear_a.timeout |=> raw_interrupt_flags_a.timeout)
    else $error("time-out flag dropped without clear");
  masked_gate_a: assert property (masked_interrupt_flags_a == (raw_interrupt_flags_a & interrupt_mask_a))
    else $error("masked flags differ from raw and mask");
  irq_or_a: assert property (controller_interrupt == (|masked_interrupt_flags_a || |masked_interrupt_flags_b || rtc_masked_flag))
    else $error("controller interrupt wrong");
  stall_freeze_a: assert property (tmr_a_w && timer_a_ctl.stall_enable && debug_halt && !load_a_wr && !set_enable_a && !clear_enable_a |=> $stable(timer_a_count_capture))
    else $error("count moved during stall");
  load_take_a: assert property (tmr_a_w && timer_a_enable && load_a_wr && !debug_halt && !clear_enable_a |=> timer_a_count_capture == $past(load_a_data))
    else $error("rewritten load not taken");
  oneshot_stop_a: assert property (tmr_a_w && timer_a_mode_reg.mode_field == MODE_ONE_SHOT && $rose(raw_interrupt_flags_a.timeout) |-> !timer_a_enable)
    else $error("one-shot still enabled after time-out");
  match_stop_a: assert property (split_w && timer_a_mode_reg.mode_field == MODE_CAPTURE && !timer_a_mode_reg.capture_mode_bit && $rose(raw_interrupt_flags_a.cap_match) |-> !timer_a_enable)
    else $error("edge count still enabled after match");
  pwm_quiet_b: assert property (split_w && timer_b_mode_reg == {MODE_PERIODIC, 1'b0, 1'b1} && raw_interrupt_flags_b == '0 |=> raw_interrupt_flags_b == '0)
    else $error("flag set in pwm mode");
  rtc_step_a: assert property (timer_configuration_reg == CFG_32_RTC && $past(timer_configuration_reg) == CFG_32_RTC && !$stable(rtc_count) |-> rtc_count == $past(rtc_count) + 32'h1 || rtc_count == RTC_ROLL_VALUE)
    else $error("rtc count jumped");
endmodule
bind general_timer_module timer_props props (.*);

/* File: testbench/edge_source.sv */
`timescale 1ns/10ps
module edge_source (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Request
  input  wire logic       go,
  input  wire logic [7:0] pulses,
  // Pin side
  output logic            pin,
  output logic            busy
);
  logic [7:0] left_r;
  logic [2:0] ph_r;
  // Three clocks high, three low: margin over the two-clock minimum
  always_ff @(posedge ref_clk) begin
    if (rst || go) begin
      left_r <= rst ? 8'h00 : pulses;
      ph_r <= 3'h0;
    end else if (left_r != 8'h00) begin
      ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
      left_r <= (ph_r == 3'h5) ? left_r - 8'h01 : left_r;
    end
  end
  assign pin = left_r != 8'h00 && ph_r < 3'h3;
  assign busy = left_r != 8'h00;
endmodule

/* File: testbench/general_timer_module_bench.sv */
`timescale 1ns/10ps
module general_timer_module_bench;
  import gen_timer_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, rtc_enable_bit = 1'b0, debug_halt = 1'b0;
  logic [2:0] timer_configuration_reg = 3'h0;
  timer_mode_s timer_a_mode_reg = '0, timer_b_mode_reg = '0;
  timer_ctl_s timer_a_ctl = '0, timer_b_ctl = '0;
  logic set_enable_a = '0, set_enable_b = '0, clear_enable_a = '0, clear_enable_b = '0;
  logic [15:0] load_a_data = '0, load_b_data = '0;
  logic [15:0] timer_a_match_value = '0, timer_b_match_value = '0;
  logic load_a_wr = '0, load_b_wr = '0, prescale_a_wr = '0, prescale_b_wr = '0, rtc_flag_clear = '0;
  logic [7:0] prescale_a_data = '0, prescale_b_data = '0, np_a = '0, np_b = '0;
  timer_irq_s interrupt_mask_a = '0, interrupt_mask_b = '0, interrupt_clear_a = '0;
  timer_irq_s interrupt_clear_b = '0, raw_interrupt_flags_a, raw_interrupt_flags_b;
  timer_irq_s masked_interrupt_flags_a, masked_interrupt_flags_b;
  logic rtc_interrupt_mask = '0, go_a = '0, go_b = '0;
  logic capture_compare_pin_a, capture_compare_pin_b;
  logic timer_a_enable, timer_b_enable, rtc_raw_flag, rtc_masked_flag, busy_a, busy_b;
  logic controller_interrupt, adc_trigger, pwm_out_a, pwm_out_b;
  logic [15:0] timer_a_count_capture, timer_b_count_capture, v1, v2;
  logic [31:0] rtc_count;
  int num_errors = 0, compares = 0, cycles = 0;

  general_timer_module dut (.*);
  edge_source src_a (.ref_clk(ref_clk), .rst(rst), .go(go_a), .pulses(np_a),
                     .pin(capture_compare_pin_a), .busy(busy_a));
  edge_source src_b (.ref_clk(ref_clk), .rst(rst), .go(go_b), .pulses(np_b),
                     .pin(capture_compare_pin_b), .busy(busy_b));

  always #20 ref_clk = ~ref_clk;
  // Whole run needs about three hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      close_out();
    end
  end

  task close_out;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Strobes for timer a (b=0) or b (b=1), one cycle each
  task load(input logic b, input logic [15:0] v);
    {load_a_data, load_b_data} = {v, v};
    {load_b_wr, load_a_wr} = {b, !b};
    tick(1);
    {load_b_wr, load_a_wr, prescale_a_wr} = 3'h0;
  endtask
  task enab(input logic b);
    {set_enable_b, set_enable_a} = {b, !b};
    tick(1);
    {set_enable_b, set_enable_a} = 2'h0;
  endtask
  task clr;
    {clear_enable_a, clear_enable_b, interrupt_clear_a, interrupt_clear_b} = '1;
    tick(1);
    {clear_enable_a, clear_enable_b, interrupt_clear_a, interrupt_clear_b} = '0;
  endtask
  task pulses_a(input logic [7:0] n);
    np_a = n;
    go_a = 1'b1;
    tick(1);
    go_a = 1'b0;
    for (int i = 0; i < 100 && busy_a; i++) tick(1);
    tick(6);
  endtask
  task wait_evt_b;
    for (int i = 0; i < 60 && raw_interrupt_flags_b.cap_event !== 1'b1; i++) tick(1);
  endtask

  task t_periodic;
    int last;
    last = -1;
    timer_configuration_reg = CFG_16_SPLIT;
    timer_a_mode_reg = {MODE_PERIODIC, 2'b00};
    timer_a_ctl.adc_trigger_enable = 1'b1;
    interrupt_mask_a.timeout = 1'b1;
    prescale_a_data = 8'h01;
    prescale_a_wr = 1'b1;
    load(0, 16'h0002);
    enab(0);
    for (int i = 0; i < 40; i++) begin
      tick(1);
      if (adc_trigger === 1'b1) begin
        if (last >= 0) chk(i - last == 6, "prescaled period");
        last = i;
      end
    end
    chk(raw_interrupt_flags_a.timeout === 1'b1 && controller_interrupt === 1'b1, "timeout");
    load(0, 16'h0064);
    chk(timer_a_count_capture === 16'h0064, "load rewrite");
    interrupt_clear_a.timeout = 1'b1;
    tick(1);
    interrupt_clear_a.timeout = 1'b0;
    chk(raw_interrupt_flags_a.timeout === 1'b0, "flag clear");
    timer_a_ctl.stall_enable = 1'b1;
    debug_halt = 1'b1;
    tick(1);
    v1 = timer_a_count_capture;
    tick(6);
    chk(timer_a_count_capture === v1, "stall freeze");
    debug_halt = 1'b0;
    tick(4);
    chk(timer_a_count_capture !== v1, "stall resume");
    timer_a_ctl.stall_enable = 1'b0;
    clr();
  endtask

  task t_oneshot;
    timer_a_mode_reg = {MODE_ONE_SHOT, 2'b00};
    prescale_a_data = 8'h00;
    prescale_a_wr = 1'b1;
    load(0, 16'h0003);
    enab(0);
    for (int i = 0; i < 30 && timer_a_enable === 1'b1; i++) tick(1);
    chk(raw_interrupt_flags_a.timeout === 1'b1 && timer_a_enable === 1'b0, "one-shot");
    tick(5);
    chk(timer_a_count_capture === 16'h0003, "one-shot reload and stop");
    clr();
  endtask

  task t_edge_count;
    logic [1:0] ev[3];
    ev = '{EVT_RISING, EVT_FALLING, EVT_BOTH};
    timer_a_mode_reg = {MODE_CAPTURE, 2'b00};
    timer_a_match_value = 16'h0006;
    interrupt_mask_a.cap_match = 1'b1;
    for (int s = 0; s < 3; s++) begin
      timer_a_ctl.edge_event_select = ev[s];
      load(0, 16'h000a);
      enab(0);
      pulses_a(8'h03);
      if (s < 2) begin
        chk(timer_a_count_capture === 16'h0007, "partial edge count");
        chk(raw_interrupt_flags_a.cap_match === 1'b0, "no early match");
        pulses_a(8'h01);
      end
      chk(raw_interrupt_flags_a.cap_match === 1'b1, "match flag");
      chk(timer_a_enable === 1'b0 && timer_a_count_capture === 16'h000a, "stop");
      clr();
    end
  endtask

  task t_edge_time;
    timer_b_mode_reg = {MODE_CAPTURE, 1'b1, 1'b0};
    timer_b_ctl.edge_event_select = EVT_RISING;
    interrupt_mask_b.cap_event = 1'b1;
    enab(1);
    np_b = 8'h02;
    go_b = 1'b1;
    tick(1);
    go_b = 1'b0;
    wait_evt_b();
    v1 = timer_b_count_capture;
    chk(masked_interrupt_flags_b.cap_event === 1'b1, "capture flag");
    interrupt_clear_b.cap_event = 1'b1;
    tick(1);
    interrupt_clear_b.cap_event = 1'b0;
    wait_evt_b();
    v2 = timer_b_count_capture;
    chk(v1 - v2 === 16'h0006, "capture spacing");
    tick(10);
    chk(timer_b_count_capture === v2, "capture held");
    clr();
  endtask

  task t_pwm;
    int hi;
    timer_b_mode_reg = {MODE_PERIODIC, 1'b0, 1'b1};
    timer_b_match_value = 16'h0002;
    load(1, 16'h0009);
    enab(1);
    chk(timer_b_enable === 1'b1, "pwm timer enabled");
    chk(pwm_out_a === 1'b0, "pwm a idle outside pwm mode");
    for (int k = 0; k < 2; k++) begin
      timer_b_ctl.pwm_output_invert = k[0];
      tick(10);
      hi = 0;
      repeat (20) begin
        tick(1);
        hi += int'(pwm_out_b === 1'b1);
      end
      chk(hi == (k == 0 ? 14 : 6), "pwm duty");
    end
    chk(raw_interrupt_flags_b === 3'h0, "pwm sets no flag");
    clr();
  endtask

  task t_rtc;
    // Tick needs 32768 slow edges, too long here; first load only
    timer_configuration_reg = CFG_32_RTC;
    rtc_enable_bit = 1'b1;
    enab(0);
    tick(3);
    chk(rtc_count === RTC_FIRST_LOAD, "rtc first load");
    chk(rtc_raw_flag === 1'b0, "no rtc match before a tick");
  endtask

  initial begin
    tick(3);
    rst = 1'b0;
    tick(1);
    chk(timer_a_count_capture === LOAD_RESET && timer_b_count_capture === LOAD_RESET, "reset");
    t_periodic();
    t_oneshot();
    t_edge_count();
    t_edge_time();
    t_pwm();
    t_rtc();
    close_out();
  end
endmodule
